/* rtl/sslsd_defines.vh */
// Shared constants of the serial shift and latch sink driver
`ifndef SSLSD_DEFINES_VH
`define SSLSD_DEFINES_VH

// System clock
`define SSLSD_CLK_PERIOD_NS 10

// Datapath sizes
`define SSLSD_CHANNELS 16
`define SSLSD_FIFO_DEPTH 32
`define SSLSD_FIFO_ADDR_W 5
`define SSLSD_STORE_RESET 16'h0000

// Event word layout, one word per shift clock or storage strobe change
`define SSLSD_EV_W 4
`define SSLSD_EV_RISE 3
`define SSLSD_EV_FALL 2
`define SSLSD_EV_BIT 1
`define SSLSD_EV_OPEN 0

// Positions in the sampled pin vector
`define SSLSD_PIN_W 4
`define SSLSD_PIN_CLK 0
`define SSLSD_PIN_DATA 1
`define SSLSD_PIN_STORE 2
`define SSLSD_PIN_OUTG 3
`define SSLSD_PIN_RESET 4'h8

// Least pulse widths and the fastest shift clock
`define SSLSD_T_CLK_PULSE_NS 20
`define SSLSD_T_STORE_PULSE_NS 20
`define SSLSD_T_OUTG_PULSE_NS 400
`define SSLSD_F_SHIFT_MAX_MHZ 25
`define SSLSD_T_SHIFT_PERIOD_NS (1000 / `SSLSD_F_SHIFT_MAX_MHZ)

// Least times as whole cycles, rounded up
`define SSLSD_CLK_PULSE_CYC \
    ((`SSLSD_T_CLK_PULSE_NS + `SSLSD_CLK_PERIOD_NS - 1) / `SSLSD_CLK_PERIOD_NS)
`define SSLSD_STORE_PULSE_CYC \
    ((`SSLSD_T_STORE_PULSE_NS + `SSLSD_CLK_PERIOD_NS - 1) / `SSLSD_CLK_PERIOD_NS)
`define SSLSD_OUTG_PULSE_CYC \
    ((`SSLSD_T_OUTG_PULSE_NS + `SSLSD_CLK_PERIOD_NS - 1) / `SSLSD_CLK_PERIOD_NS)
`define SSLSD_SHIFT_PERIOD_CYC \
    ((`SSLSD_T_SHIFT_PERIOD_NS + `SSLSD_CLK_PERIOD_NS - 1) / `SSLSD_CLK_PERIOD_NS)

// Run-length counters saturate here
`define SSLSD_RUN_W 6
`define SSLSD_RUN_MAX 6'h3f

`endif

/* rtl/sslsd_fifo.v */
// Event FIFO with registered read data and valid/ready on both sides
`timescale 1ns/1ns
module sslsd_fifo #(
    parameter WIDTH = 4,
    parameter DEPTH = 32,
    parameter ADDR_W = 5
) (
    // Clock and reset
    input wire i_clk,
    input wire i_arst_n,
    // Filling side
    input wire i_wr_valid,
    input wire [WIDTH-1:0] i_wr_data,
    output wire o_wr_ready,
    // Draining side
    output reg o_rd_valid,
    output reg [WIDTH-1:0] o_rd_data,
    input wire i_rd_ready
);

    // DEPTH must equal 2**ADDR_W so the pointers wrap by themselves
    localparam [ADDR_W:0] FULL_CNT = DEPTH[ADDR_W:0];

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [ADDR_W-1:0] wr_ptr;
    reg [ADDR_W-1:0] rd_ptr;
    reg [ADDR_W:0] cnt;
    wire push;
    wire pop_mem;

    // Full is honest: the array alone, not the output register
    assign o_wr_ready = (cnt != FULL_CNT);
    assign push = i_wr_valid & o_wr_ready;
    assign pop_mem = (cnt != {(ADDR_W+1){1'b0}}) & (~o_rd_valid | i_rd_ready);

    // Storage array, no reset needed
    always @(posedge i_clk)
    begin
        if (push)
            mem[wr_ptr] <= i_wr_data;
    end

    // Pointers, fill count and the output register
    always @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            wr_ptr <= {ADDR_W{1'b0}};
            rd_ptr <= {ADDR_W{1'b0}};
            cnt <= {(ADDR_W+1){1'b0}};
            o_rd_valid <= 1'b0;
            o_rd_data <= {WIDTH{1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop_mem)
            begin
                rd_ptr <= rd_ptr + 1'b1;
                o_rd_data <= mem[rd_ptr];
                o_rd_valid <= 1'b1;
            end
            else if (i_rd_ready)
                o_rd_valid <= 1'b0;
            case ({push, pop_mem})
                2'b10: cnt <= cnt + 1'b1;
                2'b01: cnt <= cnt - 1'b1;
                default: cnt <= cnt;
            endcase
        end
    end

endmodule // sslsd_fifo

/* rtl/sslsd_pin_sampler.v */
// Registers the controller pins and flags their edges
`timescale 1ns/1ns
module sslsd_pin_sampler #(
    parameter WIDTH = 4,
    parameter [WIDTH-1:0] RESET_LEVEL = 4'h8
) (
    // Clock and reset
    input wire i_clk,
    input wire i_arst_n,
    // Raw pins
    input wire [WIDTH-1:0] i_pins,
    // Sampled levels and one-cycle edge pulses
    output reg [WIDTH-1:0] o_level,
    output reg [WIDTH-1:0] o_rise,
    output reg [WIDTH-1:0] o_fall
);

    // One stage per pin; pins are synchronous to i_clk
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : g_pin
            always @(posedge i_clk or negedge i_arst_n)
            begin
                if (!i_arst_n)
                begin
                    o_level[g] <= RESET_LEVEL[g];
                    o_rise[g] <= 1'b0;
                    o_fall[g] <= 1'b0;
                end
                else
                begin
                    o_level[g] <= i_pins[g];
                    o_rise[g] <= i_pins[g] & ~o_level[g];
                    o_fall[g] <= ~i_pins[g] & o_level[g];
                end
            end
        end
    endgenerate

endmodule // sslsd_pin_sampler

/* rtl/sslsd_top.v */
// Sixteen-channel serial shift, storage latch and gated sink driver
// Pins are sampled on i_clk; every shift clock or storage strobe change becomes one event word that
// passes a FIFO before the shift engine applies it, so the engine may be
// held off with i_hold without losing edges until the FIFO is full.
`timescale 1ns/1ns
`include "sslsd_defines.vh"
module sslsd_top #(
    parameter CHANNELS = `SSLSD_CHANNELS,
    parameter FIFO_DEPTH = `SSLSD_FIFO_DEPTH,
    parameter FIFO_ADDR_W = `SSLSD_FIFO_ADDR_W
) (
    // Clock and reset
    input wire i_clk,
    input wire i_arst_n,
    // Controller pins
    input wire i_shift_clk,
    input wire i_serial_in,
    input wire i_store_gate_n,
    input wire i_out_gate_n,
    // Cascade output
    output reg o_serial_out,
    // Sink channel controls, high means sinking
    output reg [CHANNELS-1:0] o_sink_on,
    // Event buffer control and state
    input wire i_hold,
    output wire o_in_ready,
    output reg o_overrun,
    // Timing monitor
    input wire i_fault_clear,
    output reg [`SSLSD_PIN_W-1:0] o_pulse_fault,
    output reg o_rate_fault
);

    // Least pulse widths in cycles, sized for the run counters
    localparam integer CLK_PULSE_CYC = `SSLSD_CLK_PULSE_CYC;
    localparam integer STORE_PULSE_CYC = `SSLSD_STORE_PULSE_CYC;
    localparam integer OUTG_PULSE_CYC = `SSLSD_OUTG_PULSE_CYC;
    localparam integer SHIFT_PERIOD_CYC = `SSLSD_SHIFT_PERIOD_CYC;
    localparam [`SSLSD_RUN_W-1:0] CLK_MIN = CLK_PULSE_CYC[`SSLSD_RUN_W-1:0];
    localparam [`SSLSD_RUN_W-1:0] STORE_MIN = STORE_PULSE_CYC[`SSLSD_RUN_W-1:0];
    localparam [`SSLSD_RUN_W-1:0] OUTG_MIN = OUTG_PULSE_CYC[`SSLSD_RUN_W-1:0];
    localparam [`SSLSD_RUN_W-1:0] DATA_MIN = 6'h01;
    localparam [`SSLSD_RUN_W-1:0] PERIOD_MIN = SHIFT_PERIOD_CYC[`SSLSD_RUN_W-1:0];
    localparam [`SSLSD_PIN_W*`SSLSD_RUN_W-1:0] MIN_VEC =
        {OUTG_MIN, STORE_MIN, DATA_MIN, CLK_MIN};

    // Sampled pins
    wire [`SSLSD_PIN_W-1:0] raw_pins;
    wire [`SSLSD_PIN_W-1:0] pin_level;
    wire [`SSLSD_PIN_W-1:0] pin_rise;
    wire [`SSLSD_PIN_W-1:0] pin_fall;

    // Event path
    wire ev_push_req;
    wire [`SSLSD_EV_W-1:0] ev_in;
    wire ev_valid;
    wire [`SSLSD_EV_W-1:0] ev_word;
    wire ev_pop;

    // Engine state
    reg [CHANNELS-1:0] shift_reg;
    reg [CHANNELS-1:0] store_reg;
    reg store_open;
    reg [CHANNELS-1:0] next_shift;
    reg [CHANNELS-1:0] next_store;
    reg next_open;
    reg next_serial_out;

    // Monitor state
    reg [`SSLSD_PIN_W*`SSLSD_RUN_W-1:0] run_len;
    reg [`SSLSD_RUN_W-1:0] period_len;
    wire [`SSLSD_PIN_W-1:0] pulse_short;
    wire period_short;

    // Pin order in the sampled vector
    assign raw_pins = {i_out_gate_n, i_store_gate_n, i_serial_in, i_shift_clk};

    // Output gate resets high so the sinks start off
    sslsd_pin_sampler #(
        .WIDTH(`SSLSD_PIN_W),
        .RESET_LEVEL(`SSLSD_PIN_RESET)
    ) u_sampler (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_pins(raw_pins),
        .o_level(pin_level),
        .o_rise(pin_rise),
        .o_fall(pin_fall)
    );

    // One event per shift edge or storage strobe change
    assign ev_push_req = pin_rise[`SSLSD_PIN_CLK] | pin_fall[`SSLSD_PIN_CLK]
        | pin_rise[`SSLSD_PIN_STORE] | pin_fall[`SSLSD_PIN_STORE];

    // Data bit rides with the rising edge that samples it
    assign ev_in = {pin_rise[`SSLSD_PIN_CLK], pin_fall[`SSLSD_PIN_CLK],
        pin_level[`SSLSD_PIN_DATA], pin_level[`SSLSD_PIN_STORE]};

    // Engine drains one event per cycle unless held
    assign ev_pop = ev_valid & ~i_hold;

    // Buffer between pin edges and the shift engine
    sslsd_fifo #(
        .WIDTH(`SSLSD_EV_W),
        .DEPTH(FIFO_DEPTH),
        .ADDR_W(FIFO_ADDR_W)
    ) u_fifo (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_wr_valid(ev_push_req),
        .i_wr_data(ev_in),
        .o_wr_ready(o_in_ready),
        .o_rd_valid(ev_valid),
        .o_rd_data(ev_word),
        .i_rd_ready(~i_hold)
    );

    // Edge lost when the buffer is full; sticky, set wins over clear
    always @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_overrun <= 1'b0;
        else
            o_overrun <= (o_overrun & ~i_fault_clear) | (ev_push_req & ~o_in_ready);
    end

    // Next state of the shift engine for the event at the FIFO head
    always @*
    begin
        next_shift = shift_reg;
        next_serial_out = o_serial_out;
        next_open = store_open;
        if (ev_pop)
        begin
            // New bit enters stage 0, older bits move one stage up
            if (ev_word[`SSLSD_EV_RISE])
                next_shift = {shift_reg[CHANNELS-2:0], ev_word[`SSLSD_EV_BIT]};
            // Cascade pin moves only on the falling shift edge
            if (ev_word[`SSLSD_EV_FALL])
                next_serial_out = shift_reg[CHANNELS-1];
            next_open = ev_word[`SSLSD_EV_OPEN];
        end
        // Open latch passes the shift stages, closed latch keeps its word
        if (next_open)
            next_store = next_shift;
        else
            next_store = store_reg;
    end

    // Shift register, storage latch and cascade output
    always @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            shift_reg <= `SSLSD_STORE_RESET;
            store_reg <= `SSLSD_STORE_RESET;
            store_open <= 1'b0;
            o_serial_out <= 1'b0;
        end
        else
        begin
            shift_reg <= next_shift;
            store_reg <= next_store;
            store_open <= next_open;
            o_serial_out <= next_serial_out;
        end
    end

    // Channel drivers; the gate is applied straight from the pin so that
    // blanking is never delayed behind events waiting in the buffer
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1)
        begin : g_chan
            always @(posedge i_clk or negedge i_arst_n)
            begin
                if (!i_arst_n)
                    o_sink_on[ch] <= 1'b0;
                else if (pin_level[`SSLSD_PIN_OUTG])
                    o_sink_on[ch] <= 1'b0;
                else
                    o_sink_on[ch] <= store_reg[ch];
            end
        end
    endgenerate

    // Run length of each pin level, compared with its least width at
    // the next edge; counters saturate so long levels never wrap
    genvar p;
    generate
        for (p = 0; p < `SSLSD_PIN_W; p = p + 1)
        begin : g_mon
            wire pin_edge;
            wire [`SSLSD_RUN_W-1:0] run_now;
            wire [`SSLSD_RUN_W-1:0] run_min;
            assign pin_edge = pin_rise[p] | pin_fall[p];
            assign run_now = run_len[p*`SSLSD_RUN_W +: `SSLSD_RUN_W];
            assign run_min = MIN_VEC[p*`SSLSD_RUN_W +: `SSLSD_RUN_W];
            assign pulse_short[p] = pin_edge & (run_now < run_min);

            always @(posedge i_clk or negedge i_arst_n)
            begin
                if (!i_arst_n)
                    run_len[p*`SSLSD_RUN_W +: `SSLSD_RUN_W] <= `SSLSD_RUN_MAX;
                else if (pin_edge)
                    run_len[p*`SSLSD_RUN_W +: `SSLSD_RUN_W] <= 6'h01;
                else if (run_now != `SSLSD_RUN_MAX)
                    run_len[p*`SSLSD_RUN_W +: `SSLSD_RUN_W] <= run_now + 1'b1;
            end

            // Sticky short-pulse flag; a new fault beats a clear
            always @(posedge i_clk or negedge i_arst_n)
            begin
                if (!i_arst_n)
                    o_pulse_fault[p] <= 1'b0;
                else
                    o_pulse_fault[p] <= (o_pulse_fault[p] & ~i_fault_clear) | pulse_short[p];
            end
        end
    endgenerate

    // Shift clock period, rising edge to rising edge
    assign period_short = pin_rise[`SSLSD_PIN_CLK] & (period_len < PERIOD_MIN);

    // Period counter starts saturated so the first edge is never flagged
    always @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            period_len <= `SSLSD_RUN_MAX;
        else if (pin_rise[`SSLSD_PIN_CLK])
            period_len <= 6'h01;
        else if (period_len != `SSLSD_RUN_MAX)
            period_len <= period_len + 1'b1;
    end

    // Sticky over-rate flag; a new fault beats a clear
    always @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_rate_fault <= 1'b0;
        else
            o_rate_fault <= (o_rate_fault & ~i_fault_clear) | period_short;
    end

endmodule // sslsd_top

/* testbench/sslsd_ctrl_model.sv */
// Controller model driving the shift, data, strobe and gate pins
`timescale 1ns/1ns
module sslsd_ctrl_model (
    // Clock
    input wire i_clk,
    // Controller pins
    output reg o_shift_clk,
    output reg o_serial_in,
    output reg o_store_gate_n,
    output reg o_out_gate_n
);
    // Idle: clock low, latch closed, channels blanked
    initial
    begin
        o_shift_clk = 1'b0;
        o_serial_in = 1'b0;
        o_store_gate_n = 1'b0;
        o_out_gate_n = 1'b1;
    end
    // Pins only move 1 ns after an edge
    task tick(input integer n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // Data goes with the rise; 2 high plus 2 low keeps 40 ns, i.e. 25 MHz
    task shift_bit(input b);
    begin
        o_serial_in = b;
        o_shift_clk = 1'b1;
        tick(2);
        o_shift_clk = 1'b0;
        tick(2);
    end
    endtask
    // Top bit first so it ends on channel 15; line then shows a stale inverse
    task shift_word(input [15:0] w);
        integer i;
    begin
        for (i = 15; i >= 0; i = i - 1)
            shift_bit(w[i]);
        o_serial_in = ~o_serial_in;
    end
    endtask
    // Strobe pulse after a full word, 20 ns wide
    task pulse_store;
    begin
        o_store_gate_n = 1'b1;
        tick(2);
        o_store_gate_n = 1'b0;
        tick(2);
    end
    endtask
    task set_store(input b);
    begin
        o_store_gate_n = b;
        tick(2);
    end
    endtask
    // Gate level is held past its 400 ns least width
    task set_gate(input b);
    begin
        o_out_gate_n = b;
        tick(45);
    end
    endtask
    // Deliberately one cycle high and low, to trip the rate and width monitor
    task fast_clock;
        repeat (6)
        begin
            o_shift_clk = 1'b1;
            tick(1);
            o_shift_clk = 1'b0;
            tick(1);
        end
    endtask
    // Gate high well short of its least width, then held low again
    task gate_blink;
    begin
        o_out_gate_n = 1'b1;
        tick(10);
        o_out_gate_n = 1'b0;
        tick(45);
    end
    endtask
endmodule // sslsd_ctrl_model

/* testbench/sslsd_top_chk.sv */
// Concurrent checks on the sink driver's ports
`timescale 1ns/1ns
module sslsd_top_chk #(
    parameter CHANNELS = 16
) (
    // Clock and reset
    input wire i_clk,
    input wire i_arst_n,
    // Controller pins
    input wire i_shift_clk,
    input wire i_serial_in,
    input wire i_store_gate_n,
    input wire i_out_gate_n,
    input wire i_hold,
    // Outputs
    input wire o_serial_out,
    input wire [CHANNELS-1:0] o_sink_on
);
    reg [3:0] since_fall;
    reg [5:0] since_hold;
    wire calm;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);

    // Cycles since the last falling shift edge, saturating so it never wraps
    always @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            since_fall <= 4'hf;
        else if ($fell(i_shift_clk))
            since_fall <= 4'h0;
        else if (since_fall != 4'hf)
            since_fall <= since_fall + 4'h1;
    end

    // Cycles since the engine was last stalled; a held backlog drains late
    always @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            since_hold <= 6'h3f;
        else if (i_hold)
            since_hold <= 6'h00;
        else if (since_hold != 6'h3f)
            since_hold <= since_hold + 6'h01;
    end
    // Backlog of 33 events is surely gone once this is reached
    assign calm = (since_hold == 6'h3f);

    // Rising shift edge carrying a given data level
    sequence s_rise(b);
        $rose(i_shift_clk) && (i_serial_in == b);
    endsequence
    // Latch open, gate on, no stall and no further shift for five cycles
    sequence s_quiet;
        (i_store_gate_n && !i_out_gate_n && !i_hold && !$rose(i_shift_clk))[*5];
    endsequence
    sequence s_blank;
        i_out_gate_n[*4];
    endsequence

    AST_SO_AFTER_FALL: assert property (
        $changed(o_serial_out) && $past(i_arst_n) && calm |->
        (since_fall >= 4'h1) && (since_fall <= 4'h8))
        else $error("serial out moved without a recent falling shift edge");
    AST_SO_IDLE_STABLE: assert property (
        (!i_shift_clk && calm)[*8] |-> $stable(o_serial_out))
        else $error("serial out moved while the shift clock stayed low");
    AST_GATE_OFF: assert property (
        s_blank |-> (o_sink_on == {CHANNELS{1'b0}}))
        else $error("a channel sinks while the output gate is high");
    AST_GATE_BLANK_FAST: assert property (
        $rose(i_out_gate_n) |-> ##[1:3] (o_sink_on == {CHANNELS{1'b0}}))
        else $error("channels not blanked soon after the gate rose");
    AST_ON_NEEDS_GATE: assert property (
        $changed(o_sink_on) && (o_sink_on != {CHANNELS{1'b0}}) |->
        !$past(i_out_gate_n, 2) || !$past(i_out_gate_n, 3) || !$past(i_out_gate_n, 4))
        else $error("channels switched on without the gate low");
    AST_HOLD_LOW: assert property (
        (!i_store_gate_n && !i_out_gate_n)[*8] |-> $stable(o_sink_on))
        else $error("channels changed while the latch was closed");
    AST_STAGE0_ONE: assert property (
        s_rise(1'b1) ##1 s_quiet |-> o_sink_on[0])
        else $error("a shifted one did not reach channel 0");
    AST_STAGE0_ZERO: assert property (
        s_rise(1'b0) ##1 s_quiet |-> !o_sink_on[0])
        else $error("a shifted zero did not clear channel 0");
endmodule // sslsd_top_chk

/* testbench/tb.sv */
// Self-checking bench for the sixteen-channel sink driver
`timescale 1ns/1ns
module tb;
    reg clk;
    reg arst_n;
    reg hold;
    reg fault_clear;
    wire shift_clk;
    wire serial_in;
    wire store_gate_n;
    wire out_gate_n;
    wire serial_out;
    wire [15:0] sink_on;
    wire in_ready;
    wire overrun;
    wire [3:0] pulse_fault;
    wire rate_fault;
    integer mismatches;
    integer cmp_count;

    sslsd_ctrl_model ctrl (
        .i_clk(clk), .o_shift_clk(shift_clk), .o_serial_in(serial_in),
        .o_store_gate_n(store_gate_n), .o_out_gate_n(out_gate_n));
    sslsd_top sslsd_top_inst (
        .i_clk(clk), .i_arst_n(arst_n), .i_shift_clk(shift_clk),
        .i_serial_in(serial_in), .i_store_gate_n(store_gate_n),
        .i_out_gate_n(out_gate_n), .o_serial_out(serial_out), .o_sink_on(sink_on),
        .i_hold(hold), .o_in_ready(in_ready), .o_overrun(overrun),
        .i_fault_clear(fault_clear), .o_pulse_fault(pulse_fault),
        .o_rate_fault(rate_fault));

    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task tk(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Gate level and word travel as variables into the controller model
    task gate_to(input lvl);
    begin
        ctrl.set_gate(lvl);
    end
    endtask
    task load_word(input [15:0] w);
    begin
        ctrl.shift_word(w);
    end
    endtask
    task chk(input string nm, input [15:0] exp, input [15:0] got);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    end
    endtask
    task wrap_up;
    begin
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask

    // Latched load, then a second word that must stay hidden until strobed
    task t_load;
    begin
        gate_to(1'b0);
        load_word(16'hA5C3);
        ctrl.pulse_store;
        tk(8);
        chk("sink load", 16'hA5C3, sink_on);
        load_word(16'h3C96);
        tk(8);
        chk("sink held", 16'hA5C3, sink_on);
        ctrl.pulse_store;
        tk(8);
        chk("sink next", 16'h3C96, sink_on);
        $display("t_load done");
    end
    endtask
    // Open latch follows every shift
    task t_transparent;
    begin
        ctrl.set_store(1'b1);
        load_word(16'h8001);
        tk(8);
        chk("sink open", 16'h8001, sink_on);
        ctrl.shift_bit(1'b0);
        tk(8);
        chk("sink open shift", 16'h0002, sink_on);
        ctrl.set_store(1'b0);
        $display("t_transparent done");
    end
    endtask
    // Cascade output shows stage 15 after each falling edge
    task t_serial_out;
        reg [31:0] pair;
        integer k;
    begin
        pair = {16'h0002, 16'h5A0F};
        for (k = 1; k <= 16; k = k + 1)
        begin
            ctrl.shift_bit(pair[16 - k]);
            tk(3);
            chk("serial_out", {15'h0000, pair[31 - k]}, {15'h0000, serial_out});
        end
        $display("t_serial_out done");
    end
    endtask
    // Gate high blanks all, even across a strobe; low shows the new word
    task t_gate;
    begin
        gate_to(1'b1);
        chk("sink gated", 16'h0000, sink_on);
        ctrl.pulse_store;
        tk(8);
        chk("sink gated strobe", 16'h0000, sink_on);
        gate_to(1'b0);
        chk("sink ungated", 16'h5A0F, sink_on);
        $display("t_gate done");
    end
    endtask
    // Stall the engine, overfill the buffer, drain, clear the sticky flag
    task t_buffer;
    begin
        gate_to(1'b1);
        hold = 1'b1;
        // 64 shift edges against room for 33 events, so the tail is lost
        load_word(16'hFFFF);
        load_word(16'hFFFF);
        chk("in_ready full", 16'h0000, {15'h0000, in_ready});
        chk("overrun set", 16'h0001, {15'h0000, overrun});
        hold = 1'b0;
        tk(60);
        chk("in_ready drained", 16'h0001, {15'h0000, in_ready});
        chk("faults", 16'h0000, {11'h000, pulse_fault, rate_fault});
        fault_clear = 1'b1;
        tk(1);
        fault_clear = 1'b0;
        tk(2);
        chk("overrun cleared", 16'h0000, {15'h0000, overrun});
        gate_to(1'b0);
        chk("sink after drain", 16'h5A0F, sink_on);
        $display("t_buffer done");
    end
    endtask
    // Too fast a shift clock and too short a gate pulse set sticky flags
    task t_faults;
    begin
        ctrl.fast_clock;
        ctrl.gate_blink;
        chk("faults set", 16'h0013, {11'h000, pulse_fault, rate_fault});
        chk("sink after blink", 16'h5A0F, sink_on);
        fault_clear = 1'b1;
        tk(1);
        fault_clear = 1'b0;
        tk(2);
        chk("faults cleared", 16'h0000, {11'h000, pulse_fault, rate_fault});
        $display("t_faults done");
    end
    endtask

    // Watchdog: the run needs well under 1500 cycles
    initial
    begin
        repeat (3000) @(posedge clk);
        mismatches = mismatches + 1;
        wrap_up;
    end

    initial
    begin
        mismatches = 0;
        cmp_count = 0;
        arst_n = 1'b0;
        hold = 1'b0;
        fault_clear = 1'b0;
        repeat (16) @(posedge clk);
        #1;
        arst_n = 1'b1;
        tk(2);
        t_load;
        t_transparent;
        t_serial_out;
        t_gate;
        t_buffer;
        t_faults;
        wrap_up;
    end
endmodule // tb

bind sslsd_top sslsd_top_chk #(.CHANNELS(CHANNELS)) sslsd_top_chk_inst (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_shift_clk(i_shift_clk),
    .i_serial_in(i_serial_in), .i_store_gate_n(i_store_gate_n),
    .i_out_gate_n(i_out_gate_n), .i_hold(i_hold),
    .o_serial_out(o_serial_out), .o_sink_on(o_sink_on));
